// file: common/ctsr_pkg.sv
// Shared constants and types for the common trigger and status registers
package ctsr_pkg;
    localparam int NCHAN = 4;
    // Register offsets
    localparam logic [7:0] CFG_ADDR  = 8'h1f;
    localparam logic [7:0] TRIG_ADDR = 8'h20;
    localparam logic [7:0] CLR_ADDR  = 8'h21;
    localparam logic [7:0] STAT_ADDR = 8'h22;
    localparam logic [7:0] CMP_ADDR  = 8'h23;
    // Trigger register fields
    localparam int KEY_LSB    = 12;
    localparam int RST_LSB    = 8;
    localparam int PROG_BIT   = 1;
    localparam int RELOAD_BIT = 0;
    localparam logic [3:0] UNLOCK_KEY      = 4'h5;
    localparam logic [3:0] SOFT_RESET_CODE = 4'ha;
    localparam logic [3:0] KEY_RESET       = 4'h0;
    // Lock bit in the configuration register
    localparam int LOCK_BIT = 14;
    // Comparator clear bits: channel n at CLR_TOP - CLR_STEP * n
    localparam int CLR_TOP  = 15;
    localparam int CLR_STEP = 4;
    // Status and comparator flag register fields
    localparam int TRIM_FAIL_BIT  = 15;
    localparam int USER_FAIL_BIT  = 14;
    localparam int CHAN_BUSY_LSB  = 9;
    localparam int STORE_BUSY_BIT = 8;
    localparam int PART_LSB       = 2;
    localparam int REV_LSB        = 0;
    localparam int CMP_FLAG_LSB   = 0;
    // Identity values, arbitrary
    localparam logic [5:0] PART_ID = 6'h2d;
    localparam logic [1:0] REV_ID  = 2'h1;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [15:0] data;
    } ctsr_bus_req_type;

    typedef struct packed {
        logic prog;
        logic reload;
    } ctsr_store_cmd_type;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_PROG   = 2'b01,
        ST_RELOAD = 2'b10
    } ctsr_store_state_type;
endpackage

// file: src/ctsr_sync.sv
// Three-stage comparator output synchroniser with agreement filter
module ctsr_sync
(
    // Clock and reset
    input  logic                       clk,
    input  logic                       rst_b,
    // Comparator outputs
    input  logic [ctsr_pkg::NCHAN-1:0] cmpRaw,
    output logic [ctsr_pkg::NCHAN-1:0] cmpFlag
);
    import ctsr_pkg::*;

    logic [NCHAN-1:0] stage1;
    logic [NCHAN-1:0] stage2;
    logic [NCHAN-1:0] stage3;
    logic [NCHAN-1:0] next_cmpFlag;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    genvar ch;
    generate
        for (ch = 0; ch < NCHAN; ch++)
        begin : g_chan
            // Change counts once stages two and three agree
            assign next_cmpFlag[ch] = (stage2[ch] == stage3[ch]) ?
                                      stage3[ch] : cmpFlag[ch];

            a_flag_agree: assert property (
                (stage2[ch] == stage3[ch]) |=>
                    cmpFlag[ch] == $past(stage3[ch]))
                else $error("comparator flag missed agreed value");
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            stage1  <= '0;
            stage2  <= '0;
            stage3  <= '0;
            cmpFlag <= '0;
        end
        else
        begin
            stage1  <= cmpRaw;
            stage2  <= stage1;
            stage3  <= stage2;
            cmpFlag <= next_cmpFlag;
        end
    end
endmodule

// file: src/ctsr_store_seq.sv
// Program and reload sequencer for the nonvolatile store
module ctsr_store_seq
(
    // Clock and reset
    input  logic                          clk,
    input  logic                          rst_b,
    // Requests from the trigger register
    input  logic                          progReq,
    input  logic                          reloadReq,
    input  logic                          softReset,
    output logic                          progTake,
    output logic                          reloadTake,
    // Store side
    output ctsr_pkg::ctsr_store_cmd_type  storeCmd,
    input  logic                          storeDone,
    input  logic                          storeCrcBad,
    input  logic                          storeBusyIn,
    // Status
    output logic                          storeBusy,
    output logic                          userFailSet
);
    import ctsr_pkg::*;

    ctsr_store_state_type state;
    ctsr_store_state_type next_state;
    ctsr_store_cmd_type   next_storeCmd;
    logic                 next_userFailSet;
    logic                 idleFree;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    // Store counts busy while external store or sequence is active
    assign storeBusy  = (state != ST_IDLE) || storeBusyIn;
    assign idleFree   = !storeBusy && !softReset;
    assign progTake   = idleFree && progReq;
    assign reloadTake = idleFree && reloadReq && !progReq;

    always_comb
    begin
        next_state       = state;
        next_storeCmd    = '0;
        next_userFailSet = 1'b0;
        case (state)
            ST_IDLE:
            begin
                if (progTake)
                begin
                    next_state         = ST_PROG;
                    next_storeCmd.prog = 1'b1;
                end
                else if (reloadTake)
                begin
                    next_state           = ST_RELOAD;
                    next_storeCmd.reload = 1'b1;
                end
            end
            ST_PROG:
            begin
                if (storeDone)
                begin
                    next_state = ST_IDLE;
                end
            end
            ST_RELOAD:
            begin
                if (storeDone)
                begin
                    next_state       = ST_IDLE;
                    next_userFailSet = storeCrcBad;
                end
            end
            default:
            begin
                next_state = ST_IDLE;
            end
        endcase
        if (softReset)
        begin
            next_state = ST_IDLE;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state       <= ST_IDLE;
            storeCmd    <= '0;
            userFailSet <= 1'b0;
        end
        else
        begin
            state       <= next_state;
            storeCmd    <= next_storeCmd;
            userFailSet <= next_userFailSet;
        end
    end

    a_busy_flag: assert property (
        storeBusyIn |-> storeBusy && !progTake && !reloadTake)
        else $error("store start taken while store busy");

    a_prog_cmd: assert property (
        progTake |=> storeCmd.prog && state == ST_PROG
                     ##1 !storeCmd.prog)
        else $error("program command not a single pulse");

    a_reload_fail: assert property (
        state == ST_RELOAD && storeDone && storeCrcBad && !softReset
        |=> userFailSet && state == ST_IDLE)
        else $error("reload check failure not reported");

    c_prog_done: cover property (state == ST_PROG && storeDone);
endmodule

// file: src/ctsr_common_regs.sv
// Common trigger, comparator clear and general status registers
module ctsr_common_regs
(
    // Clock and reset
    input  logic                          clk,
    input  logic                          rst_b,
    // Register access
    input  ctsr_pkg::ctsr_bus_req_type    busReq,
    output logic [15:0]                   rdData,
    output logic                          rdValid,
    // Device control
    output logic                          softReset,
    output logic                          registerLock,
    output logic [ctsr_pkg::NCHAN-1:0]    cmpClear,
    // Channel state
    input  logic [ctsr_pkg::NCHAN-1:0]    chanBusy,
    input  logic [ctsr_pkg::NCHAN-1:0]    cmpRaw,
    // Factory trim load
    input  logic                          trimLoadDone,
    input  logic                          trimCrcBad,
    // Nonvolatile store
    output ctsr_pkg::ctsr_store_cmd_type  storeCmd,
    input  logic                          storeDone,
    input  logic                          storeCrcBad,
    input  logic                          storeBusyIn
);
    import ctsr_pkg::*;

    logic [3:0]       keyField;
    logic [3:0]       next_keyField;
    logic             unlockArmed;
    logic             next_unlockArmed;
    logic             lockBit;
    logic             next_lockBit;
    logic             progReq;
    logic             next_progReq;
    logic             reloadReq;
    logic             next_reloadReq;
    logic             trimFail;
    logic             next_trimFail;
    logic             userFail;
    logic             next_userFail;
    logic             next_softReset;
    logic [NCHAN-1:0] next_cmpClear;
    logic [15:0]      next_rdData;
    logic             next_rdValid;
    logic             progTake;
    logic             reloadTake;
    logic             storeBusy;
    logic             userFailSet;
    logic [NCHAN-1:0] cmpFlag;
    logic             wrTrig;
    logic             wrClr;
    logic             wrCfg;
    logic [3:0]       wrKey;
    logic [3:0]       wrReset;

    // Write decode
    assign wrTrig       = busReq.wr && (busReq.addr == TRIG_ADDR);
    assign wrClr        = busReq.wr && (busReq.addr == CLR_ADDR);
    assign wrCfg        = busReq.wr && (busReq.addr == CFG_ADDR);
    assign wrKey        = busReq.data[KEY_LSB +: 4];
    assign wrReset      = busReq.data[RST_LSB +: 4];
    assign registerLock = lockBit;

    // Store sequencer
    ctsr_store_seq u_store_seq
    (
        .clk         (clk),
        .rst_b       (rst_b),
        .progReq     (progReq),
        .reloadReq   (reloadReq),
        .softReset   (softReset),
        .progTake    (progTake),
        .reloadTake  (reloadTake),
        .storeCmd    (storeCmd),
        .storeDone   (storeDone),
        .storeCrcBad (storeCrcBad),
        .storeBusyIn (storeBusyIn),
        .storeBusy   (storeBusy),
        .userFailSet (userFailSet)
    );

    // Comparator synchroniser
    ctsr_sync u_sync
    (
        .clk     (clk),
        .rst_b   (rst_b),
        .cmpRaw  (cmpRaw),
        .cmpFlag (cmpFlag)
    );

    // Control state next values
    always_comb
    begin
        next_keyField    = keyField;
        next_unlockArmed = unlockArmed;
        next_lockBit     = lockBit;
        next_progReq     = progReq;
        next_reloadReq   = reloadReq;
        next_trimFail    = trimFail;
        next_userFail    = userFail;
        next_softReset   = 1'b0;
        next_cmpClear    = '0;
        if (progTake)
        begin
            next_progReq = 1'b0;
        end
        if (reloadTake)
        begin
            next_reloadReq = 1'b0;
        end
        if (softReset)
        begin
            // Power-on equivalent clear of the key, lock, request and fail state
            next_keyField    = KEY_RESET;
            next_unlockArmed = 1'b0;
            next_lockBit     = 1'b0;
            next_progReq     = 1'b0;
            next_reloadReq   = 1'b0;
            next_trimFail    = 1'b0;
            next_userFail    = 1'b0;
        end
        else
        begin
            if (wrTrig)
            begin
                next_keyField    = wrKey;
                next_unlockArmed = (wrKey == UNLOCK_KEY);
                if (!lockBit)
                begin
                    next_softReset = (wrReset == SOFT_RESET_CODE);
                    if (busReq.data[PROG_BIT])
                    begin
                        next_progReq = 1'b1;
                    end
                    if (busReq.data[RELOAD_BIT])
                    begin
                        next_reloadReq = 1'b1;
                    end
                end
            end
            if (wrCfg)
            begin
                if (busReq.data[LOCK_BIT])
                begin
                    next_lockBit = 1'b1;
                end
                else if (unlockArmed)
                begin
                    next_lockBit = 1'b0;
                end
                next_unlockArmed = 1'b0;
            end
            if (wrClr && !lockBit)
            begin
                for (int ch = 0; ch < NCHAN; ch++)
                begin
                    next_cmpClear[ch] =
                        busReq.data[CLR_TOP - CLR_STEP * ch];
                end
            end
        end
        // Hardware set wins over reset clear
        if (trimLoadDone && trimCrcBad)
        begin
            next_trimFail = 1'b1;
        end
        if (userFailSet)
        begin
            next_userFail = 1'b1;
        end
    end

    // Read data
    always_comb
    begin
        next_rdValid = busReq.rd;
        next_rdData  = '0;
        if (busReq.rd)
        begin
            case (busReq.addr)
                TRIG_ADDR:
                begin
                    next_rdData[KEY_LSB +: 4]  = keyField;
                    next_rdData[PROG_BIT]      = progReq;
                    next_rdData[RELOAD_BIT]    = reloadReq;
                end
                CFG_ADDR:
                begin
                    next_rdData[LOCK_BIT] = lockBit;
                end
                STAT_ADDR:
                begin
                    next_rdData[TRIM_FAIL_BIT]          = trimFail;
                    next_rdData[USER_FAIL_BIT]          = userFail;
                    next_rdData[CHAN_BUSY_LSB +: NCHAN] = chanBusy;
                    next_rdData[STORE_BUSY_BIT]         = storeBusy;
                    next_rdData[PART_LSB +: 6]          = PART_ID;
                    next_rdData[REV_LSB +: 2]           = REV_ID;
                end
                CMP_ADDR:
                begin
                    next_rdData[CMP_FLAG_LSB +: NCHAN] = cmpFlag;
                end
                default:
                begin
                    next_rdData = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            keyField    <= KEY_RESET;
            unlockArmed <= 1'b0;
            lockBit     <= 1'b0;
            progReq     <= 1'b0;
            reloadReq   <= 1'b0;
            trimFail    <= 1'b0;
            userFail    <= 1'b0;
            softReset   <= 1'b0;
            cmpClear    <= '0;
            rdData      <= '0;
            rdValid     <= 1'b0;
        end
        else
        begin
            keyField    <= next_keyField;
            unlockArmed <= next_unlockArmed;
            lockBit     <= next_lockBit;
            progReq     <= next_progReq;
            reloadReq   <= next_reloadReq;
            trimFail    <= next_trimFail;
            userFail    <= next_userFail;
            softReset   <= next_softReset;
            cmpClear    <= next_cmpClear;
            rdData      <= next_rdData;
            rdValid     <= next_rdValid;
        end
    end

    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    a_key_arms: assert property (
        wrTrig && !softReset |=> unlockArmed == (keyField == UNLOCK_KEY))
        else $error("unlock arming does not follow key");

    a_lock_hold: assert property (
        lockBit && wrTrig && !softReset && !progReq && !reloadReq
        |=> !progReq && !reloadReq && !softReset)
        else $error("locked trigger write took effect");

    a_unlock_seq: assert property (
        lockBit && !softReset && wrCfg && !busReq.data[LOCK_BIT]
        |=> lockBit == !$past(unlockArmed))
        else $error("lock cleared without key");

    a_soft_reset: assert property (
        wrTrig && !lockBit && !softReset && wrReset == SOFT_RESET_CODE
        |=> softReset ##1 !softReset && !lockBit && keyField == KEY_RESET)
        else $error("soft reset pulse or clear wrong");

    a_prog_pend: assert property (
        wrTrig && !lockBit && !softReset && busReq.data[PROG_BIT]
        |=> progReq)
        else $error("program request not latched");

    a_reload_run: assert property (
        reloadTake |=> storeCmd.reload && !reloadReq[*1])
        else $error("reload not started or not self-cleared");

    a_clear_map: assert property (
        wrClr && !lockBit && !softReset && busReq.data[CLR_TOP]
        |=> cmpClear[0] ##1 !cmpClear[0])
        else $error("channel 0 clear pulse wrong");

    a_trim_set: assert property (
        trimLoadDone && trimCrcBad |=> trimFail)
        else $error("trim check failure lost");

    a_user_set: assert property (
        userFailSet |=> userFail)
        else $error("user store failure lost");

    a_chan_busy: assert property (
        busReq.rd && busReq.addr == STAT_ADDR
        |=> rdValid && rdData[CHAN_BUSY_LSB +: NCHAN] == $past(chanBusy))
        else $error("channel busy bits wrong");

    a_id_fixed: assert property (
        busReq.rd && busReq.addr == STAT_ADDR
        |=> rdData[PART_LSB +: 6] == PART_ID
            && rdData[REV_LSB +: 2] == REV_ID)
        else $error("identifier bits wrong");

    c_unlock: cover property (
        lockBit && wrTrig && wrKey == UNLOCK_KEY
        ##2 wrCfg && !busReq.data[LOCK_BIT] ##1 !lockBit);
    c_soft_reset: cover property (softReset);
    c_reload: cover property (reloadTake);
    c_clear_all: cover property (&cmpClear);
endmodule

// file: verif/ctsr_common_regs_bench.sv
// Self-checking bench for the common trigger and status registers
`define CHK(got, exp, msg) \
    begin \
        checks++; \
        if ((got) !== (exp)) \
        begin \
            failures++; \
            $display("CHECK FAILED %0t %s", $time, msg); \
        end \
    end

module ctsr_common_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import ctsr_pkg::*;

    logic               clk;
    logic               rst_b;
    ctsr_bus_req_type   busReq;
    logic [15:0]        rdData;
    logic               rdValid;
    logic               softReset;
    logic               registerLock;
    logic [3:0]         cmpClear;
    logic [3:0]         chanBusy;
    logic [3:0]         cmpRaw;
    logic               trimLoadDone;
    logic               trimCrcBad;
    ctsr_store_cmd_type storeCmd;
    logic               storeDone;
    logic               storeCrcBad;
    logic               storeBusyIn;
    int                 failures;
    int                 checks;
    int                 softCnt;
    int                 progCnt;
    int                 reloadCnt;
    int                 clrCnt [4];

    ctsr_common_regs uut
    (
        .clk          (clk),
        .rst_b        (rst_b),
        .busReq       (busReq),
        .rdData       (rdData),
        .rdValid      (rdValid),
        .softReset    (softReset),
        .registerLock (registerLock),
        .cmpClear     (cmpClear),
        .chanBusy     (chanBusy),
        .cmpRaw       (cmpRaw),
        .trimLoadDone (trimLoadDone),
        .trimCrcBad   (trimCrcBad),
        .storeCmd     (storeCmd),
        .storeDone    (storeDone),
        .storeCrcBad  (storeCrcBad),
        .storeBusyIn  (storeBusyIn)
    );

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Pulse counters for the one-cycle outputs
    always @(posedge clk)
    begin
        if (softReset === 1'b1) softCnt++;
        if (storeCmd.prog === 1'b1) progCnt++;
        if (storeCmd.reload === 1'b1) reloadCnt++;
        for (int i = 0; i < 4; i++)
            if (cmpClear[i] === 1'b1) clrCnt[i]++;
    end

    function automatic logic [15:0] stat(input logic t, input logic u,
                                         input logic [3:0] b, input logic s);
        return {t, u, 1'b0, b, s, PART_ID, REV_ID};
    endfunction

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        busReq = '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
        idle(1);
        busReq = '0;
        idle(1);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
        busReq = '{wr: 1'b0, rd: 1'b1, addr: a, data: 16'h0000};
        idle(1);
        busReq = '0;
        `CHK(rdValid, 1'b1, "read not answered")
        `CHK(rdData, e, "read data")
        idle(1);
    endtask

    task automatic done(input logic bad);
        storeCrcBad = bad;
        storeDone = 1'b1;
        idle(1);
        storeDone = 1'b0;
        storeCrcBad = 1'b0;
    endtask

    task automatic end_sim;
        $display("failures=%0d checks=%0d", failures, checks);
        if (failures == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial
    begin
        #5000;
        failures++;
        end_sim();
    end

    initial
    begin
        rst_b = 1'b0;
        busReq = '0;
        {chanBusy, cmpRaw, trimLoadDone, trimCrcBad} = '0;
        {storeDone, storeCrcBad, storeBusyIn} = '0;
        {failures, checks, softCnt, progCnt, reloadCnt} = '0;
        clrCnt = '{0, 0, 0, 0};
        repeat (5) @(posedge clk);
        #1;
        rst_b = 1'b1;
        // Reset values, write-only and unmapped reads
        `CHK(registerLock, 1'b0, "lock after reset")
        rdchk(TRIG_ADDR, 16'h0000);
        rdchk(STAT_ADDR, stat(1'b0, 1'b0, 4'h0, 1'b0));
        rdchk(CLR_ADDR, 16'h0000);
        rdchk(8'h40, 16'h0000);
        // Channel busy bits
        for (int i = 0; i < 4; i++)
        begin
            chanBusy = 4'h1 << i;
            rdchk(STAT_ADDR, stat(1'b0, 1'b0, 4'h1 << i, 1'b0));
        end
        chanBusy = 4'h0;
        // Status is read-only
        wr(STAT_ADDR, 16'hffff);
        rdchk(STAT_ADDR, stat(1'b0, 1'b0, 4'h0, 1'b0));
        // Program held off while the store is busy
        storeBusyIn = 1'b1;
        wr(TRIG_ADDR, 16'h0002);
        idle(3);
        `CHK(progCnt, 0, "program while store busy")
        rdchk(TRIG_ADDR, 16'h0002);
        storeBusyIn = 1'b0;
        idle(3);
        `CHK(progCnt, 1, "program start")
        rdchk(STAT_ADDR, stat(1'b0, 1'b0, 4'h0, 1'b1));
        rdchk(TRIG_ADDR, 16'h0000);
        // Reload waits for program to finish, then fails its check
        wr(TRIG_ADDR, 16'h0001);
        idle(3);
        `CHK(reloadCnt, 0, "reload while busy")
        done(1'b0);
        idle(3);
        `CHK(reloadCnt, 1, "reload start")
        rdchk(TRIG_ADDR, 16'h0000);
        done(1'b1);
        idle(1);
        rdchk(STAT_ADDR, stat(1'b0, 1'b1, 4'h0, 1'b0));
        // Factory trim check failure
        {trimLoadDone, trimCrcBad} = 2'b11;
        idle(1);
        {trimLoadDone, trimCrcBad} = 2'b00;
        rdchk(STAT_ADDR, stat(1'b1, 1'b1, 4'h0, 1'b0));
        // Soft reset code, wrong code first
        wr(TRIG_ADDR, 16'h5b00);
        idle(2);
        `CHK(softCnt, 0, "wrong reset code")
        wr(TRIG_ADDR, 16'h0a00);
        idle(2);
        `CHK(softCnt, 1, "soft reset pulse")
        rdchk(STAT_ADDR, stat(1'b0, 1'b0, 4'h0, 1'b0));
        rdchk(TRIG_ADDR, 16'h0000);
        // Comparator clears, one channel each
        for (int n = 0; n < 4; n++)
        begin
            wr(CLR_ADDR, 16'h8000 >> (4 * n));
            idle(2);
            `CHK(clrCnt[n], 1, "comparator clear")
        end
        wr(CLR_ADDR, 16'h0000);
        idle(2);
        for (int n = 0; n < 4; n++)
            `CHK(clrCnt[n], 1, "stray comparator clear")
        // Locked device refuses triggers
        wr(CFG_ADDR, 16'h4000);
        `CHK(registerLock, 1'b1, "lock set")
        wr(TRIG_ADDR, 16'h0a03);
        wr(CLR_ADDR, 16'h8888);
        idle(3);
        `CHK(softCnt + progCnt + reloadCnt, 3, "trigger while locked")
        `CHK(clrCnt[0] + clrCnt[3], 2, "clear while locked")
        wr(CFG_ADDR, 16'h0000);
        `CHK(registerLock, 1'b1, "unlock without key")
        wr(TRIG_ADDR, 16'h6000);
        wr(CFG_ADDR, 16'h0000);
        `CHK(registerLock, 1'b1, "unlock with wrong key")
        wr(TRIG_ADDR, 16'h5000);
        wr(CFG_ADDR, 16'h0000);
        `CHK(registerLock, 1'b0, "unlock with key")
        rdchk(CFG_ADDR, 16'h0000);
        // Synchronised comparator flags
        cmpRaw = 4'ha;
        idle(6);
        rdchk(CMP_ADDR, 16'h000a);
        cmpRaw = 4'h5;
        idle(6);
        rdchk(CMP_ADDR, 16'h0005);
        // Power cycle clears the trim failure
        {trimLoadDone, trimCrcBad} = 2'b11;
        idle(1);
        {trimLoadDone, trimCrcBad} = 2'b00;
        rdchk(STAT_ADDR, stat(1'b1, 1'b0, 4'h0, 1'b0));
        rst_b = 1'b0;
        idle(2);
        rst_b = 1'b1;
        rdchk(STAT_ADDR, stat(1'b0, 1'b0, 4'h0, 1'b0));
        end_sim();
    end
endmodule
